//--- src/ivp_pkg.sv
// Shared constants and types for the interrupt vector placement block.
// Assumes a 16K-word program flash and an APB register port.
package ivp_pkg;

  // Register map, byte addresses on APB
  localparam int unsigned APB_AW   = 8;
  localparam int unsigned APB_DW   = 32;
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  STAT_OFS = 8'h04;
  localparam logic [7:0]  BASE_OFS = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_CE_BIT  = 0;
  localparam int unsigned CTRL_SEL_BIT = 1;
  localparam logic        SEL_RESET    = 1'b0;

  // Status register fields
  localparam int unsigned STAT_SEQ_BIT  = 0;
  localparam int unsigned STAT_LOCK_BIT = 1;
  localparam int unsigned STAT_FUSE_LSB = 2;

  // Program word addresses
  localparam int unsigned PC_W          = 14;
  localparam int unsigned VEC_NUM_W     = 5;
  localparam logic [13:0] RESET_WORD    = 14'h0000;
  localparam logic [13:0] APP_VEC_BASE  = 14'h0000;
  localparam int unsigned VEC_SLOT_SHIFT = 1;
  // Boot section start per size fuse code 3,2,1,0 (MSB first)
  localparam logic [55:0] BOOT_START_TBL = {14'h3F00, 14'h3E00, 14'h3C00, 14'h3800};

  // Change window, in clock cycles
  localparam int unsigned CNT_W               = 3;
  localparam logic [2:0]  CHANGE_WINDOW_CYCLES = 3'h4;

  typedef struct packed {
    logic       boot_reset;
    logic [1:0] boot_size;
    logic       app_lock;
    logic       boot_lock;
  } ivp_fuse_s;

  // Unprogrammed fuses read as one
  localparam logic [4:0] FUSE_RESET = 5'h1F;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ARMED = 2'b01,
    SEQ_HOLD  = 2'b10
  } ivp_seq_e;

endpackage

//--- src/ivp_change_seq.sv
// Timed change sequence for the vector-select bit.
// Assumes single-cycle write pulses and an instruction-retire pulse on pclk.
`timescale 1ns/10ps
`default_nettype none
module ivp_change_seq (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_enable,
  input  wire logic write_select,
  input  wire logic instr_done,
  output logic      select_take,
  output logic      next_seq_block,
  output logic      change_enable,
  output logic      seq_block
);
  import ivp_pkg::*;

  ivp_seq_e         state;
  ivp_seq_e         next_state;
  logic [CNT_W-1:0] cnt;

  always_comb begin
    next_state  = state;
    select_take = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (set_enable) next_state = SEQ_ARMED;
      end
      SEQ_ARMED: begin
        if (set_enable) begin
          next_state = SEQ_ARMED;
        end else if (write_select) begin
          select_take = 1'b1;
          next_state  = SEQ_HOLD;
        end else if (cnt == 3'h1) begin
          next_state = SEQ_IDLE;
        end
      end
      SEQ_HOLD: begin
        if (set_enable) next_state = SEQ_ARMED;
        else if (instr_done) next_state = SEQ_IDLE;
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  assign next_seq_block = (next_state != SEQ_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= SEQ_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt           <= '0;
      change_enable <= 1'b0;
    end else begin
      change_enable <= (next_state == SEQ_ARMED);
      if (set_enable) cnt <= CHANGE_WINDOW_CYCLES;
      else if (cnt != '0) cnt <= cnt - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seq_block <= 1'b0;
    else seq_block <= next_seq_block;
  end

  chk_enable_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(change_enable) ##0 (!write_select && !set_enable)[*4]) |=> !change_enable)
    else $error("change enable not cleared after four cycles");

  chk_release_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(change_enable) ##0 (!write_select && !set_enable)[*4]) |=> !seq_block)
    else $error("interrupts still blocked after unused window");

  chk_block_enable: assert property (@(posedge pclk) disable iff (!presetn)
    change_enable |-> seq_block)
    else $error("interrupts not blocked while change enabled");

  chk_hold_write: assert property (@(posedge pclk) disable iff (!presetn)
    (select_take && !set_enable) |=> (seq_block && !change_enable))
    else $error("block dropped at vector-select write");

endmodule
`default_nettype wire

//--- src/ivp_vector_addr.sv
// Reset and vector fetch address generation from fuses and select.
// Assumes fuses already synchronised to pclk.
`timescale 1ns/10ps
`default_nettype none
module ivp_vector_addr (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire ivp_pkg::ivp_fuse_s      fuse,
  input  wire logic                    vector_select,
  input  wire logic [ivp_pkg::VEC_NUM_W-1:0] vector_num,
  output logic [ivp_pkg::PC_W-1:0]     boot_start,
  output logic [ivp_pkg::PC_W-1:0]     reset_addr,
  output logic [ivp_pkg::PC_W-1:0]     vector_addr
);
  import ivp_pkg::*;

  logic [PC_W-1:0] next_boot_start;
  logic [PC_W-1:0] vec_base;

  assign next_boot_start = BOOT_START_TBL[{4'h0, fuse.boot_size} * 14 +: 14];
  assign vec_base = vector_select ? next_boot_start : APP_VEC_BASE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_start  <= RESET_WORD;
      reset_addr  <= RESET_WORD;
      vector_addr <= APP_VEC_BASE;
    end else begin
      boot_start <= next_boot_start;
      reset_addr <= fuse.boot_reset ? RESET_WORD : next_boot_start;
      vector_addr <= vec_base + (PC_W'(vector_num) << VEC_SLOT_SHIFT);
    end
  end

  // follow from the base and reset choices above
  chk_reset_place: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> reset_addr == ($past(fuse.boot_reset) ? 14'h0000 : $past(next_boot_start)))
    else $error("reset address does not follow boot reset fuse");

  chk_vector_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> vector_addr == $past(vec_base) + 14'($past(vector_num)) * 14'h2)
    else $error("vector fetch address wrong");

  chk_boot_2k: assert property (@(posedge pclk) disable iff (!presetn)
    (fuse.boot_size == 2'h1 && vector_select && vector_num == 5'h19) |=> vector_addr == 14'h3C32)
    else $error("last boot vector not at 3C32");

endmodule
`default_nettype wire

//--- src/ivp_top.sv
// Interrupt vector placement: vector select register, protected change,
// interrupt blocking and vector address generation, on an APB slave port.
// Assumes fuse levels arrive asynchronously; core signals share pclk.
//
// Operation
// - select zero flash start, one boot
// - boot start derives from size fuse
// - block from enable set until after next
// - unused window releases block after four cycles
// - global interrupt enable left untouched
// - enable self-clears after four cycles or write
// - select changes only with enable set before
// - boot vectors, app lock: block app code
// - app vectors, boot lock: block boot code
// - reset zero, boot vectors at 3C02..3C32
// - boot reset 3C00, vectors from 0002
// - boot reset 3C00, vectors from 3C02
// - fuse one unprogrammed, zero programmed
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ivp_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ivp_pkg::APB_AW-1:0]    paddr,
  input  wire logic [ivp_pkg::APB_DW-1:0]    pwdata,
  output logic [ivp_pkg::APB_DW-1:0]         prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire ivp_pkg::ivp_fuse_s            fuse_pins,
  input  wire logic [ivp_pkg::PC_W-1:0]      exec_pc,
  input  wire logic                          instr_done,
  input  wire logic [ivp_pkg::VEC_NUM_W-1:0] vector_num,
  output logic                               vector_table_select,
  output logic                               vector_change_enable,
  output logic                               irq_blocked,
  output logic [ivp_pkg::PC_W-1:0]           reset_addr,
  output logic [ivp_pkg::PC_W-1:0]           vector_addr
);
  import ivp_pkg::*;

  // Fuse synchroniser stages
  logic [4:0]      fuse_meta;
  logic [4:0]      fuse_sync;
  ivp_fuse_s       fuse;

  // Bus decode
  logic            setup_phase;
  logic            access_done;
  logic            wr_go;
  logic            ctrl_wr;
  logic            set_enable;
  logic            write_select;

  // Sequencer and block state
  logic            select_take;
  logic            next_seq_block;
  logic            seq_block;
  logic            lock_block;
  logic            in_boot;
  logic [PC_W-1:0] boot_start;

  function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
    reg_mapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == BASE_OFS);
  endfunction

  function automatic logic [APB_DW-1:0] reg_read(
    input logic [APB_AW-1:0] a,
    input logic              sel,
    input logic              ce,
    input logic              sblk,
    input logic              lblk,
    input ivp_fuse_s         f,
    input logic [PC_W-1:0]   bstart
  );
    reg_read = '0;
    case (a)
      CTRL_OFS: begin
        reg_read[CTRL_SEL_BIT] = sel;
        reg_read[CTRL_CE_BIT]  = ce;
      end
      STAT_OFS: begin
        reg_read[STAT_SEQ_BIT]                 = sblk;
        reg_read[STAT_LOCK_BIT]                = lblk;
        reg_read[STAT_FUSE_LSB +: $bits(f)]    = f;
      end
      BASE_OFS: reg_read[PC_W-1:0] = bstart;
      default:  reg_read = '0;
    endcase
  endfunction

  // Fuses are static but cross from the pin domain
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_fuse_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fuse_meta[gi] <= FUSE_RESET[gi];
          fuse_sync[gi] <= FUSE_RESET[gi];
        end else begin
          fuse_meta[gi] <= fuse_pins[gi];
          fuse_sync[gi] <= fuse_meta[gi];
        end
      end
    end
  endgenerate

  assign fuse = ivp_fuse_s'(fuse_sync);

  // APB decode; no wait state, the slave answers in the cycle after setup
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_go       = access_done && pwrite;
  assign ctrl_wr     = wr_go && (paddr == CTRL_OFS);
  assign set_enable   = ctrl_wr && pwdata[CTRL_CE_BIT];
  assign write_select = ctrl_wr && !pwdata[CTRL_CE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pready <= 1'b0;
    else pready <= setup_phase;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pslverr <= 1'b0;
    else pslverr <= setup_phase && !reg_mapped(paddr);
  end

  // Read data captured at setup so it stands still through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= reg_read(paddr, vector_table_select, vector_change_enable,
                         seq_block, lock_block, fuse, boot_start);
    end else begin
      prdata <= '0;
    end
  end

  ivp_change_seq u_seq (
    .pclk           (pclk),
    .presetn        (presetn),
    .set_enable     (set_enable),
    .write_select   (write_select),
    .instr_done     (instr_done),
    .select_take    (select_take),
    .next_seq_block (next_seq_block),
    .change_enable  (vector_change_enable),
    .seq_block      (seq_block)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vector_table_select <= SEL_RESET;
    else if (select_take) vector_table_select <= pwdata[CTRL_SEL_BIT];
  end

  ivp_vector_addr u_addr (
    .pclk          (pclk),
    .presetn       (presetn),
    .fuse          (fuse),
    .vector_select (vector_table_select),
    .vector_num    (vector_num),
    .boot_start    (boot_start),
    .reset_addr    (reset_addr),
    .vector_addr   (vector_addr)
  );

  assign in_boot = (exec_pc >= boot_start);

  assign lock_block = (vector_table_select && !fuse.app_lock && !in_boot)
                   || (!vector_table_select && !fuse.boot_lock && in_boot);

  // gate only; global enable bit is never written here
  // Lock term follows exec_pc one cycle late, a deliberate register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_blocked <= 1'b0;
    else irq_blocked <= next_seq_block || lock_block;
  end

  chk_select_guard: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(vector_table_select) |-> $past(vector_change_enable))
    else $error("vector select changed without change enable");

  chk_enable_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(vector_change_enable) |-> irq_blocked)
    else $error("interrupts not blocked when change enable set");

  chk_select_write: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_change_enable && write_select) |=>
      (vector_table_select == $past(pwdata[CTRL_SEL_BIT])) && !vector_change_enable)
    else $error("select write inside window not taken");

  chk_lock_app: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_table_select && !fuse.app_lock && exec_pc < boot_start) |=> irq_blocked)
    else $error("app code not blocked with boot vectors and lock");

  chk_lock_boot: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_table_select && !fuse.boot_lock && exec_pc >= boot_start) |=> irq_blocked)
    else $error("boot code not blocked with app vectors and lock");

  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> (pready ##1 !pready))
    else $error("pready not a single cycle after setup");

  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !reg_mapped(paddr)) |=> pslverr)
    else $error("unmapped address not flagged");

  chk_boot_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (!fuse.boot_reset && fuse.boot_size == 2'h1 && $stable(fuse)) |=> reset_addr == 14'h3C00)
    else $error("boot reset not at 3C00 with 2K boot section");

  chk_app_vectors: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_table_select && vector_num == 5'h1) |=> vector_addr == 14'h0002)
    else $error("first application vector not at 0002");

  chk_select_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !select_take |=> $stable(vector_table_select))
    else $error("vector select moved outside a guarded write");

  chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");

  chk_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !(setup_phase && !pwrite) |=> prdata == 32'h0)
    else $error("read data not zero outside a read");

  chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_phase |=> !pready)
    else $error("ready without a setup cycle");

endmodule
`default_nettype wire

//--- sim/ivp_core_model.sv
// Processor core stand-in: retires instructions, moves its pc, asks for vectors.
// Assumes the core shares pclk with the block; signals change after an edge.
`timescale 1ns/10ps
`default_nettype none
module ivp_core_model (
  input  wire logic                          pclk,
  output logic [ivp_pkg::PC_W-1:0]           exec_pc,
  output logic                               instr_done,
  output logic [ivp_pkg::VEC_NUM_W-1:0]      vector_num
);
  import ivp_pkg::*;
  initial begin
    exec_pc    = '0;
    instr_done = 1'b0;
    vector_num = '0;
  end
  // One retire pulse; the next call starts a fresh edge, so no double drive
  task automatic retire();
    @(posedge pclk);
    instr_done <= 1'b1;
    @(posedge pclk);
    instr_done <= 1'b0;
  endtask
  task automatic jump(input logic [PC_W-1:0] pc);
    @(posedge pclk);
    exec_pc <= pc;
  endtask
  task automatic fetch(input logic [VEC_NUM_W-1:0] v);
    @(posedge pclk);
    vector_num <= v;
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the vector placement block over APB.
// Assumes the core model file is compiled first; one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module tb;
  import ivp_pkg::*;
  typedef struct packed {
    ivp_fuse_s   f;
    logic        s;
    logic [4:0]  v;
    logic [13:0] r;
    logic [13:0] a;
  } ivp_row_s;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  ivp_fuse_s        fuse_pins;
  logic [13:0]      exec_pc;
  logic             instr_done;
  logic [4:0]       vector_num;
  logic             vector_table_select;
  logic             vector_change_enable;
  logic             irq_blocked;
  logic [13:0]      reset_addr;
  logic [13:0]      vector_addr;
  logic [31:0]      rdat;
  logic             rerr;
  int               err_total = 0;
  int               check_count = 0;
  int               cyc = 0;
  ivp_row_s         rows [9] = '{
    '{5'h17, 1'h1, 5'h01, 14'h0000, 14'h3C02},
    '{5'h17, 1'h1, 5'h19, 14'h0000, 14'h3C32},
    '{5'h07, 1'h0, 5'h01, 14'h3C00, 14'h0002},
    '{5'h07, 1'h1, 5'h00, 14'h3C00, 14'h3C00},
    '{5'h07, 1'h1, 5'h01, 14'h3C00, 14'h3C02},
    '{5'h1F, 1'h1, 5'h01, 14'h0000, 14'h3F02},
    '{5'h1B, 1'h1, 5'h02, 14'h0000, 14'h3E04},
    '{5'h13, 1'h1, 5'h00, 14'h0000, 14'h3800},
    '{5'h17, 1'h0, 5'h03, 14'h0000, 14'h0006}};
  ivp_top u_ivp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuse_pins(fuse_pins), .exec_pc(exec_pc), .instr_done(instr_done),
    .vector_num(vector_num), .vector_table_select(vector_table_select),
    .vector_change_enable(vector_change_enable), .irq_blocked(irq_blocked),
    .reset_addr(reset_addr), .vector_addr(vector_addr));
  ivp_core_model u_core (.pclk(pclk), .exec_pc(exec_pc), .instr_done(instr_done),
    .vector_num(vector_num));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // enable first, select with enable clear in the next transfer
  task automatic setsel(input logic v);
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, {30'h0, v, 1'b0});
    u_core.retire();
  endtask
  task automatic setfuse(input logic [4:0] f);
    @(posedge pclk);
    fuse_pins <= f;
    repeat (4) @(posedge pclk);
    #1;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    fuse_pins = FUSE_RESET;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    foreach (rows[i]) begin
      setfuse(rows[i].f);
      if (vector_table_select !== rows[i].s) setsel(rows[i].s);
      u_core.fetch(rows[i].v);
      repeat (4) @(posedge pclk);
      #1;
      `CHK(vector_table_select, rows[i].s)
      `CHK(reset_addr, rows[i].r)
      `CHK(vector_addr, rows[i].a)
    end
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK({vector_table_select, vector_change_enable, irq_blocked, pready}, 4'h0)
    `CHK({reset_addr, vector_addr, prdata, pslverr}, 61'h0)
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b1, CTRL_OFS, 32'h2);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b1, CTRL_OFS, 32'h1);
    #1;
    `CHK({vector_change_enable, irq_blocked}, 2'h3)
    repeat (3) @(posedge pclk);
    #1;
    `CHK({vector_change_enable, irq_blocked}, 2'h3)
    @(posedge pclk);
    #1;
    `CHK({vector_change_enable, irq_blocked}, 2'h0)
    apb(1'b1, CTRL_OFS, 32'h2);
    #1;
    `CHK(vector_table_select, 1'b0)
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h3);
    repeat (3) @(posedge pclk);
    #1;
    `CHK({vector_table_select, vector_change_enable}, 2'h1)
    @(posedge pclk);
    #1;
    `CHK(vector_change_enable, 1'b0)
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h2);
    #1;
    `CHK({vector_table_select, vector_change_enable, irq_blocked}, 3'h5)
    repeat (6) @(posedge pclk);
    #1;
    `CHK(irq_blocked, 1'b1)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rdat[1:0], 2'h1)
    u_core.retire();
    #1;
    `CHK(irq_blocked, 1'b0)
    setfuse(5'h15);
    `CHK(irq_blocked, 1'b1)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rdat[1:0], 2'h2)
    u_core.jump(14'h3C10);
    repeat (2) @(posedge pclk);
    #1;
    `CHK(irq_blocked, 1'b0)
    setsel(1'b0);
    setfuse(5'h16);
    `CHK(irq_blocked, 1'b1)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rdat[1:0], 2'h2)
    u_core.jump(14'h0100);
    repeat (2) @(posedge pclk);
    #1;
    `CHK(irq_blocked, 1'b0)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    apb(1'b1, BASE_OFS, 32'h0);
    apb(1'b0, BASE_OFS, 32'h0);
    `CHK({rerr, rdat}, {1'b0, 32'h3C00})
    apb(1'b0, STAT_OFS, 32'h0);
    `CHK(rdat[6:2], 5'h16)
    test_done();
  end
endmodule
`default_nettype wire
